/* rtl/ltr_core.sv */
// execution slice for literal, table, pointer, bank and rotate instructions
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module ltr_core (
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic hready_in,
	input wire logic [31:0] hwdata_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	input wire logic instr_valid_in,
	input wire logic [15:0] instr_in,
	output logic instr_ack_out,
	output logic [11:0] file_addr_out,
	output logic file_re_out,
	input wire logic [7:0] file_rdata_in,
	output logic file_we_out,
	output logic [7:0] file_wdata_out,
	input wire logic [7:0] port_b_pins_in,
	output logic prescaler_clear_out,
	output logic return_out,
	output logic table_req_out,
	output logic table_write_out,
	output logic [20:0] table_addr_out,
	output logic [7:0] table_wdata_out,
	input wire logic [7:0] table_rdata_in
);
	typedef struct packed {
		ltr_pkg::ltr_phase_t phase;
		logic [15:0] ir;
		logic ir_ok;
		logic nop_next;
		logic ptr_wait;
		logic [1:0] ptr_sel;
		logic [3:0] ptr_hi;
		logic [7:0] op;
		logic [7:0] res;
		logic [4:0] res_flags;
		logic to_file;
		logic to_work;
		logic [7:0] working_register;
		logic [4:0] status;
		logic [3:0] bank_selection_register;
		logic [2:0][11:0] file_pointer_register;
		logic [15:0] prod;
		logic [20:0] tbl_ptr;
		logic [7:0] tbl_latch;
		logic tbl_pending;
		logic [11:0] faddr;
		logic fre;
		logic fwe;
		logic psc_clr;
		logic ret;
		logic tbl_req;
		logic ext_en;
		logic psa;
		logic [7:0] pins_meta;
		logic [7:0] pins_sync;
		logic bus_wr;
		logic [7:0] bus_addr;
		logic [31:0] rdata;
	} ltr_state_t;

	ltr_state_t s;
	ltr_state_t n;

	logic take;
	logic bus_go;
	logic [7:0] hi;
	logic [7:0] k;
	logic [8:0] sum9;
	logic [4:0] nib5;
	logic [7:0] rot;

	// instruction taken only at decode phase and outside a no-operation cycle
	assign take = instr_valid_in && (s.phase == ltr_pkg::Q1) && !s.nop_next;
	assign bus_go = hsel_in && hready_in && htrans_in[1];
	assign hi = s.ir[15:8];
	assign k = s.ir[7:0];
	assign rot = {s.op[0], s.op[7:1]};

	// file address from bank bit, extended set and offset
	function automatic logic [11:0] ltr_faddr(input logic [15:0] w, input logic ext, input logic [3:0] bank,
		input logic [11:0] base);
		logic [7:0] f;
		f = w[7:0];
		if (!w[8] && ext && (f <= ltr_pkg::INDEX_LIMIT)) begin
			ltr_faddr = base + {4'h0, f};
		end else if (!w[8]) begin
			ltr_faddr = (f < ltr_pkg::ACCESS_SPLIT) ? {4'h0, f} : {ltr_pkg::ACCESS_HIGH_BANK, f};
		end else begin
			ltr_faddr = {bank, f};
		end
	endfunction

	// register read mux for the bus
	function automatic logic [31:0] ltr_read(input ltr_state_t t, input logic [7:0] a);
		ltr_read = 32'h0000_0000;
		unique case (a)
			ltr_pkg::REG_CTRL: ltr_read = {30'h0, t.psa, t.ext_en};
			ltr_pkg::REG_WORK: ltr_read = {19'h0, t.status, t.working_register};
			ltr_pkg::REG_BANK: ltr_read = {28'h0, t.bank_selection_register};
			ltr_pkg::REG_PTR0: ltr_read = {20'h0, t.file_pointer_register[0]};
			ltr_pkg::REG_PTR1: ltr_read = {20'h0, t.file_pointer_register[1]};
			ltr_pkg::REG_PTR2: ltr_read = {20'h0, t.file_pointer_register[2]};
			ltr_pkg::REG_TPTR: ltr_read = {11'h0, t.tbl_ptr};
			ltr_pkg::REG_TLAT: ltr_read = {24'h0, t.tbl_latch};
			ltr_pkg::REG_PROD: ltr_read = {16'h0, t.prod};
			default: ltr_read = 32'h0000_0000;
		endcase
	endfunction

	// next state of the whole slice
	always_comb begin
		n = s;
		sum9 = 9'h000;
		nib5 = 5'h00;
		n.fre = 1'b0;
		n.psc_clr = 1'b0;
		n.ret = 1'b0;
		n.tbl_req = 1'b0;

		// pin synchroniser
		n.pins_meta = port_b_pins_in;
		n.pins_sync = s.pins_meta;

		// bus data phase write, then address phase capture
		if (s.bus_wr) begin
			unique case (s.bus_addr)
				ltr_pkg::REG_CTRL: begin
					n.ext_en = hwdata_in[ltr_pkg::CTRL_EXT];
					n.psa = hwdata_in[ltr_pkg::CTRL_PSA];
				end
				ltr_pkg::REG_WORK: begin
					n.working_register = hwdata_in[7:0];
					n.status = hwdata_in[ltr_pkg::WORK_FLAGS_LSB +: 5];
				end
				ltr_pkg::REG_TPTR: n.tbl_ptr = hwdata_in[20:0];
				ltr_pkg::REG_TLAT: n.tbl_latch = hwdata_in[7:0];
				default: ;
			endcase
		end
		n.bus_wr = bus_go && hwrite_in;
		n.bus_addr = bus_go ? {haddr_in[7:2], 2'b00} : s.bus_addr;
		n.rdata = (bus_go && !hwrite_in) ? ltr_read(s, {haddr_in[7:2], 2'b00}) : 32'h0000_0000;

		// phase sequencing
		unique case (s.phase)
			ltr_pkg::Q1: n.phase = ltr_pkg::Q2;
			ltr_pkg::Q2: n.phase = ltr_pkg::Q3;
			ltr_pkg::Q3: n.phase = ltr_pkg::Q4;
			ltr_pkg::Q4: n.phase = ltr_pkg::Q1;
		endcase

		unique case (s.phase)
			// decode: capture word and form file address
			ltr_pkg::Q1: begin
				n.nop_next = 1'b0;
				n.ir_ok = take;
				n.ir = take ? instr_in : 16'h0000;
				n.faddr = ltr_faddr(instr_in, s.ext_en, s.bank_selection_register,
					s.file_pointer_register[ltr_pkg::INDEX_PTR]);
				n.fre = take && !s.ptr_wait && (instr_in[15:10] == ltr_pkg::OP_ROTR);
			end
			// read: operand from file, port register reads the pins
			ltr_pkg::Q2: begin
				n.op = (s.faddr == ltr_pkg::PORT_B_ADDR) ? s.pins_sync : file_rdata_in;
			end
			// process: compute result and flags
			ltr_pkg::Q3: begin
				n.to_work = 1'b0;
				n.to_file = 1'b0;
				n.res = s.working_register;
				n.res_flags = s.status;
				if (s.ir_ok && s.ptr_wait) begin
					n.to_work = 1'b0;
				end else if (s.ir_ok && (hi == ltr_pkg::OP_ADD)) begin
					sum9 = {1'b0, s.working_register} + {1'b0, k};
					nib5 = {1'b0, s.working_register[3:0]} + {1'b0, k[3:0]};
					n.res = sum9[7:0];
					n.to_work = 1'b1;
					n.res_flags[ltr_pkg::FLAG_C] = sum9[8];
					n.res_flags[ltr_pkg::FLAG_DC] = nib5[4];
					n.res_flags[ltr_pkg::FLAG_OV] = (s.working_register[7] == k[7]) && (sum9[7] != k[7]);
					n.res_flags[ltr_pkg::FLAG_Z] = (sum9[7:0] == 8'h00);
					n.res_flags[ltr_pkg::FLAG_N] = sum9[7];
				end else if (s.ir_ok && (hi == ltr_pkg::OP_RSUB)) begin
					sum9 = {1'b0, k} + {1'b0, ~s.working_register} + 9'h001;
					nib5 = {1'b0, k[3:0]} + {1'b0, ~s.working_register[3:0]} + 5'h01;
					n.res = sum9[7:0];
					n.to_work = 1'b1;
					n.res_flags[ltr_pkg::FLAG_C] = sum9[8];
					n.res_flags[ltr_pkg::FLAG_DC] = nib5[4];
					n.res_flags[ltr_pkg::FLAG_OV] = (k[7] != s.working_register[7]) && (sum9[7] != k[7]);
					n.res_flags[ltr_pkg::FLAG_Z] = (sum9[7:0] == 8'h00);
					n.res_flags[ltr_pkg::FLAG_N] = sum9[7];
				end else if (s.ir_ok && ((hi == ltr_pkg::OP_AND) || (hi == ltr_pkg::OP_OR) ||
					(hi == ltr_pkg::OP_XOR))) begin
					if (hi == ltr_pkg::OP_AND) begin
						n.res = s.working_register & k;
					end else if (hi == ltr_pkg::OP_OR) begin
						n.res = s.working_register | k;
					end else begin
						n.res = s.working_register ^ k;
					end
					n.to_work = 1'b1;
					n.res_flags[ltr_pkg::FLAG_Z] = (n.res == 8'h00);
					n.res_flags[ltr_pkg::FLAG_N] = n.res[7];
				end else if (s.ir_ok && ((hi == ltr_pkg::OP_LOAD) || (hi == ltr_pkg::OP_RET))) begin
					n.res = k;
					n.to_work = 1'b1;
				end else if (s.ir_ok && (s.ir[15:10] == ltr_pkg::OP_ROTR)) begin
					n.res = rot;
					n.to_work = !s.ir[9];
					n.to_file = s.ir[9];
					n.res_flags[ltr_pkg::FLAG_Z] = (rot == 8'h00);
					n.res_flags[ltr_pkg::FLAG_N] = rot[7];
				end
				// table pointer pre-increment before the access
				if (s.ir_ok && !s.ptr_wait && (s.ir[15:4] == ltr_pkg::OP_TABLE) && s.ir[3]) begin
					n.tbl_req = 1'b1;
					if (s.ir[1:0] == ltr_pkg::UPD_PRE_INC) begin
						n.tbl_ptr = s.tbl_ptr + 21'h000001;
					end
				end
			end
			// write: commit destination and side effects
			ltr_pkg::Q4: begin
				if (s.to_work) begin
					n.working_register = s.res;
				end
				// idle cycles leave the flags alone so a bus write to them is kept
				if (s.ir_ok) begin
					n.status = s.res_flags;
				end
				if (s.to_file && (s.faddr == ltr_pkg::TIMER_ZERO_ADDR) && s.psa) begin
					n.psc_clr = 1'b1;
				end
				if (s.ir_ok && s.ptr_wait) begin
					// second word consumed by the pointer load
					n.ptr_wait = 1'b0;
					if (s.ptr_sel != 2'h3) begin
						n.file_pointer_register[s.ptr_sel] = {s.ptr_hi, k};
					end
				end else if (s.ir_ok && (hi == ltr_pkg::OP_PTR1) && (s.ir[7:6] == 2'b00)) begin
					n.ptr_wait = 1'b1;
					n.ptr_sel = s.ir[5:4];
					n.ptr_hi = s.ir[3:0];
				end else if (s.ir_ok && (hi == ltr_pkg::OP_MUL)) begin
					n.prod = 16'(s.working_register) * 16'(k);
				end else if (s.ir_ok && (hi == ltr_pkg::OP_BANK) && (s.ir[7:4] == 4'h0)) begin
					n.bank_selection_register = s.ir[3:0];
				end else if (s.ir_ok && (hi == ltr_pkg::OP_RET)) begin
					n.ret = 1'b1;
					n.nop_next = 1'b1;
				end else if (s.tbl_pending) begin
					if (!s.ir[2]) begin
						n.tbl_latch = table_rdata_in;
					end
					n.nop_next = 1'b1;
					if (s.ir[1:0] == ltr_pkg::UPD_POST_INC) begin
						n.tbl_ptr = s.tbl_ptr + 21'h000001;
					end else if (s.ir[1:0] == ltr_pkg::UPD_POST_DEC) begin
						n.tbl_ptr = s.tbl_ptr - 21'h000001;
					end
				end
				// a lone second word falls through every branch as a no-operation
				if (s.ir_ok && !s.ptr_wait && (s.ir[15:12] == ltr_pkg::OP_SECOND)) begin
					n.nop_next = 1'b0;
				end
				n.ir_ok = 1'b0;
			end
		endcase

		// file write strobe and table request stand through the write phase
		n.fwe = (s.phase == ltr_pkg::Q3) && n.to_file;
		n.tbl_pending = n.tbl_req;
	end

	// single register of all state
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// bus answers with no wait state
	assign hrdata_out = s.rdata;
	assign hreadyout_out = 1'b1;
	assign hresp_out = 1'b0;
	assign instr_ack_out = take;

	// memory and side-effect ports
	assign file_addr_out = s.faddr;
	assign file_re_out = s.fre;
	assign file_we_out = s.fwe;
	assign file_wdata_out = s.res;
	assign prescaler_clear_out = s.psc_clr;
	assign return_out = s.ret;
	assign table_req_out = s.tbl_pending;
	assign table_write_out = s.tbl_pending && s.ir[2];
	assign table_addr_out = s.tbl_ptr;
	assign table_wdata_out = s.tbl_latch;
endmodule

/* rtl/ltr_pkg.sv */
// constants and types for the literal, table and rotate execution slice
// Functional notes
// - add immediate to working register in one cycle, update C, DC, Z, OV, N
// - and, or, xor immediate with working register, only Z and N change
// - immediate minus working register into working register, all five flags updated
// - load immediate into working register, no flag changes
// - multiply immediate by working register in one cycle, no flag changes
// - return with immediate in working register, two cycles, flags untouched
// - load four-bit immediate into bank selection register low bits, no flags
// - pointer load is two words, two cycles, giving a twelve-bit pointer value
// - table read, two cycles, low bits pick none, post-inc, post-dec, pre-inc
// - table write, two cycles, same pointer update choices as table read
// - read-modify-write of port register takes sampled pin levels as operand
// - writing the timer counter clears its prescaler when the prescaler is assigned
// - instructions changing program flow take two cycles, second is a no-operation
// - lone second word of a two-word instruction executes as a no-operation
// - rotate addressed byte right, bit 0 into bit 7, only N and Z change
// - destination bit 0 sends rotate result to working register, 1 to file
// - bank bit 0 uses access bank, bank bit 1 uses bank selection register
// - bank bit 0, extended set on, address up to 95: indexed literal offset
package ltr_pkg;
	// instruction cycle phases
	typedef enum logic [1:0] {Q1, Q2, Q3, Q4} ltr_phase_t;

	// instruction opcodes and opcode fields
	localparam logic [7:0] OP_ADD = 8'h0f;
	localparam logic [7:0] OP_AND = 8'h0b;
	localparam logic [7:0] OP_OR = 8'h09;
	localparam logic [7:0] OP_XOR = 8'h0a;
	localparam logic [7:0] OP_RSUB = 8'h08;
	localparam logic [7:0] OP_LOAD = 8'h0e;
	localparam logic [7:0] OP_MUL = 8'h0d;
	localparam logic [7:0] OP_RET = 8'h0c;
	localparam logic [7:0] OP_BANK = 8'h01;
	localparam logic [7:0] OP_PTR1 = 8'hee;
	localparam logic [3:0] OP_SECOND = 4'hf;
	localparam logic [5:0] OP_ROTR = 6'h10;
	localparam logic [11:0] OP_TABLE = 12'h000;
	localparam logic [1:0] TBL_READ = 2'h2;
	localparam logic [1:0] TBL_WRITE = 2'h3;

	// pointer update selectors
	localparam logic [1:0] UPD_NONE = 2'h0;
	localparam logic [1:0] UPD_POST_INC = 2'h1;
	localparam logic [1:0] UPD_POST_DEC = 2'h2;
	localparam logic [1:0] UPD_PRE_INC = 2'h3;

	// status flag positions
	localparam int FLAG_C = 0;
	localparam int FLAG_DC = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_OV = 3;
	localparam int FLAG_N = 4;

	// data space addressing
	localparam logic [7:0] INDEX_LIMIT = 8'h5f;
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
	localparam logic [11:0] PORT_B_ADDR = 12'hf90;
	localparam logic [11:0] TIMER_ZERO_ADDR = 12'hfd0;
	localparam int INDEX_PTR = 2;
	localparam int TBL_PTR_W = 21;

	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_WORK = 8'h04;
	localparam logic [7:0] REG_BANK = 8'h08;
	localparam logic [7:0] REG_PTR0 = 8'h0c;
	localparam logic [7:0] REG_PTR1 = 8'h10;
	localparam logic [7:0] REG_PTR2 = 8'h14;
	localparam logic [7:0] REG_TPTR = 8'h18;
	localparam logic [7:0] REG_TLAT = 8'h1c;
	localparam logic [7:0] REG_PROD = 8'h20;

	// control field positions
	localparam int CTRL_EXT = 0;
	localparam int CTRL_PSA = 1;
	localparam int WORK_FLAGS_LSB = 8;
endpackage

/* verif/ltr_mem_model.sv */
// data file and table memory standing behind the slice
`timescale 1ns/100ps
module ltr_mem_model (
	input wire logic clk_in,
	input wire logic [11:0] addr_in,
	input wire logic re_in,
	input wire logic we_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] rdata_out,
	input wire logic treq_in,
	input wire logic twrite_in,
	input wire logic [20:0] taddr_in,
	input wire logic [7:0] twdata_in,
	output logic [7:0] trdata_out
);
	logic [7:0] mem [4096];
	logic [7:0] last = 8'h00;
	logic [7:0] tw_data = 8'h00;
	logic [20:0] tw_addr = 21'h0;
	// reads only valid while selected, junk otherwise
	assign rdata_out = re_in ? mem[addr_in] : ~last;
	assign trdata_out = treq_in ? (taddr_in[7:0] ^ 8'h5a) : ~taddr_in[7:0];
	// file writes and table write capture
	always @(posedge clk_in) begin
		if (re_in) last <= mem[addr_in];
		if (we_in) mem[addr_in] <= wdata_in;
		if (treq_in && twrite_in) tw_data <= twdata_in;
		if (treq_in && twrite_in) tw_addr <= taddr_in;
	end
endmodule

/* verif/ltr_props.sv */
// port assertions for the literal, table and rotate execution slice
`timescale 1ns/100ps
module ltr_props (
	input wire logic core_clk_in,
	input wire logic resetn_in,
	input wire logic [15:0] instr_in,
	input wire logic instr_ack_out,
	input wire logic [11:0] file_addr_out,
	input wire logic file_re_out,
	input wire logic [7:0] file_rdata_in,
	input wire logic file_we_out,
	input wire logic [7:0] file_wdata_out,
	input wire logic prescaler_clear_out,
	input wire logic return_out,
	input wire logic table_req_out,
	input wire logic table_write_out
);
	logic [15:0] word;
	logic [7:0] opnd;
	default clocking dck @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);
	// hold the taken word and the operand read in Q2
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			word <= 16'h0000;
			opnd <= 8'h00;
		end else begin
			if (instr_ack_out) word <= instr_in;
			if (file_re_out) opnd <= file_rdata_in;
		end
	end
	sequence s_rot_wr;
		file_re_out ##2 file_we_out;
	endsequence
	sequence s_idle_cycle;
		!instr_ack_out [*4];
	endsequence
	one_take_a: assert property (instr_ack_out |=> !instr_ack_out [*3])
		else $error("word taken twice in one cycle");
	rot_steps_a: assert property (instr_ack_out && instr_in[15:9] == 7'h21 |=> s_rot_wr)
		else $error("rotate read or write step missing");
	rot_value_a: assert property (file_we_out && file_addr_out != ltr_pkg::PORT_B_ADDR |->
		file_wdata_out == {opnd[0], opnd[7:1]})
		else $error("rotate result wrong");
	rot_to_w_a: assert property (instr_ack_out && instr_in[15:9] == 7'h20 |=> ##2 !file_we_out)
		else $error("file written for working register destination");
	ret_pulse_a: assert property (instr_ack_out && instr_in[15:8] == 8'h0c |=> ##3 return_out)
		else $error("return pulse missing");
	ret_nop_a: assert property (return_out |-> s_idle_cycle)
		else $error("no idle cycle after return");
	tbl_pulse_a: assert property (instr_ack_out && instr_in[15:4] == 12'h000 && instr_in[3] |=>
		##2 table_req_out && table_write_out == word[2])
		else $error("table request wrong");
	tbl_nop_a: assert property (table_req_out |=> s_idle_cycle)
		else $error("no idle cycle after table op");
	access_bank_a: assert property (file_re_out && !word[8] && word[7:0] >= 8'h60 |->
		file_addr_out == {4'hf, word[7:0]})
		else $error("access bank address wrong");
	addr_hold_a: assert property (file_re_out |=> $stable(file_addr_out) [*2])
		else $error("file address moved in cycle");
	clear_cause_a: assert property (prescaler_clear_out |->
		$past(file_we_out) && file_addr_out == ltr_pkg::TIMER_ZERO_ADDR)
		else $error("prescaler clear without timer write");
endmodule
bind ltr_core ltr_props u_props (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .instr_in(instr_in),
	.instr_ack_out(instr_ack_out), .file_addr_out(file_addr_out), .file_re_out(file_re_out),
	.file_rdata_in(file_rdata_in), .file_we_out(file_we_out), .file_wdata_out(file_wdata_out),
	.prescaler_clear_out(prescaler_clear_out), .return_out(return_out), .table_req_out(table_req_out),
	.table_write_out(table_write_out));

/* verif/tb_top.sv */
// self-checking bench for the execution slice
`timescale 1ns/100ps
module tb_top;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic ivalid = 1'b0;
	logic [15:0] instr = 16'h0000;
	logic [7:0] pins = 8'h01;
	logic [31:0] hrdata;
	logic hready, ack, fre, fwe, pc_o, treq, twr;
	logic hresp;
	logic [11:0] faddr;
	logic [7:0] frd, fwd, twd, trd, iv, src, res;
	logic [20:0] taddr;
	logic [15:0] w;
	logic [11:0] ea;
	logic [3:0] cv;
	logic [31:0] q, ep, eu;
	int num_errors = 0, total_checks = 0, cyc = 0, pclr = 0, t_take = 0, t_gap = 0, n0;
	logic [15:0] lw [9] = '{16'h0e7f, 16'h0f01, 16'h0b0f, 16'h0980, 16'h0a80, 16'h0e05, 16'h0803, 16'h0d10,
		16'h0c33};
	logic [31:0] lwk [9] = '{32'h007f, 32'h1a80, 32'h0e00, 32'h1a80, 32'h0e00, 32'h0e05, 32'h10fe, 32'h10fe,
		32'h1033};
	logic [39:0] rot [8] = '{40'h4270_f70_d7_0, 40'h4070_f70_d7_0, 40'h4320_a20_00_0, 40'h4220_020_01_0,
		40'h4205_c39_02_1, 40'h4290_f90_ff_1, 40'h42d0_fd0_10_3, 40'h42d0_fd0_10_1};
	ltr_core u_dut (.core_clk_in(clk), .resetn_in(rstn), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(3'h2), .hready_in(hready), .hwdata_in(hwdata), .hrdata_out(hrdata),
		.hreadyout_out(hready), .hresp_out(hresp), .instr_valid_in(ivalid), .instr_in(instr), .instr_ack_out(ack),
		.file_addr_out(faddr), .file_re_out(fre), .file_rdata_in(frd), .file_we_out(fwe), .file_wdata_out(fwd),
		.port_b_pins_in(pins), .prescaler_clear_out(pc_o), .return_out(), .table_req_out(treq),
		.table_write_out(twr), .table_addr_out(taddr), .table_wdata_out(twd), .table_rdata_in(trd));
	ltr_mem_model u_mem (.clk_in(clk), .addr_in(faddr), .re_in(fre), .we_in(fwe), .wdata_in(fwd),
		.rdata_out(frd), .treq_in(treq), .twrite_in(twr), .taddr_in(taddr), .twdata_in(twd), .trdata_out(trd));
	initial forever #2 clk = ~clk;
	// cycle count, timeout and prescaler clear count
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (pc_o === 1'b1) pclr <= pclr + 1;
		if (cyc == 20000) begin
			num_errors++;
			stop_test();
		end
	end
	task automatic stop_test();
		if (num_errors == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one single AHB-Lite word transfer
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(r, e);
		chk({31'h0, hresp}, 32'h0);
	endtask
	// offer a word until taken, then note the take cycle
	task automatic run(input logic [15:0] x);
		@(posedge clk);
		ivalid <= 1'b1;
		instr <= x;
		do @(negedge clk); while (ack !== 1'b1);
		@(posedge clk);
		t_gap = cyc - t_take;
		t_take = cyc;
		ivalid <= 1'b0;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		rd_chk(ltr_pkg::REG_WORK, 32'h0);
		wr(8'h3c, 32'hffffffff);
		rd_chk(8'h3c, 32'h0);
		for (int i = 0; i < 9; i++) begin
			run(lw[i]);
			repeat (4) @(posedge clk);
			rd_chk(ltr_pkg::REG_WORK, lwk[i]);
		end
		rd_chk(ltr_pkg::REG_PROD, 32'h0fe0);
		run(16'h0c44);
		run(16'h0e06);
		chk(32'(t_gap), 32'd8);
		run(16'h010a);
		chk(32'(t_gap), 32'd4);
		run(16'hee15);
		run(16'hf0a7);
		run(16'hee2c);
		run(16'hf034);
		run(16'hf0ff);
		repeat (4) @(posedge clk);
		rd_chk(ltr_pkg::REG_BANK, 32'ha);
		rd_chk(ltr_pkg::REG_PTR1, 32'h5a7);
		rd_chk(ltr_pkg::REG_PTR2, 32'hc34);
		rd_chk(ltr_pkg::REG_WORK, 32'h1006);
		for (int i = 0; i < 8; i++) begin
			wr(ltr_pkg::REG_TPTR, 32'h100);
			wr(ltr_pkg::REG_TLAT, 32'hc0 + 32'(i));
			run(16'h0008 | 16'(i));
			repeat (4) @(posedge clk);
			eu = (i % 4 == 3) ? 32'h101 : 32'h100;
			ep = (i % 4 == 0) ? 32'h100 : (i % 4 == 2) ? 32'hff : 32'h101;
			rd_chk(ltr_pkg::REG_TPTR, ep);
			if (i < 4) rd_chk(ltr_pkg::REG_TLAT, {24'h0, eu[7:0] ^ 8'h5a});
			else chk({3'h0, u_mem.tw_addr, u_mem.tw_data}, {eu[20:0], 8'hc0 + 8'(i)});
		end
		for (int i = 0; i < 8; i++) begin
			{w, ea, iv, cv} = rot[i];
			wr(ltr_pkg::REG_CTRL, {28'h0, cv});
			u_mem.mem[ea] = iv;
			n0 = pclr;
			run(w);
			repeat (4) @(posedge clk);
			src = (ea == ltr_pkg::PORT_B_ADDR) ? pins : iv;
			res = {src[0], src[7:1]};
			bus(1'b0, ltr_pkg::REG_WORK, 32'h0, q);
			chk({24'h0, u_mem.mem[ea]}, {24'h0, w[9] ? res : iv});
			if (!w[9]) chk({24'h0, q[7:0]}, {24'h0, res});
			chk({30'h0, q[12], q[10]}, {30'h0, res[7], res == 8'h00});
			chk(32'(pclr - n0), (ea == ltr_pkg::TIMER_ZERO_ADDR && cv[1] && w[9]) ? 32'd1 : 32'd0);
		end
		stop_test();
	end
endmodule
